// ### inc/pin_location_selector_pkg.sv
// constants and carrier types for the alternative pin location selector
`default_nettype none
package pin_location_selector_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int NUM_CTRL = 4;
	// register offsets
	localparam logic [3:0] OFS_CTRL_LOGIC_EVENT = 4'h0;
	localparam logic [3:0] OFS_CTRL_COMM = 4'h1;
	localparam logic [3:0] OFS_CTRL_WAVEFORM = 4'h2;
	localparam logic [3:0] OFS_CTRL_TIMER_B = 4'h3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;
	// implemented bits of each control register, index = offset
	localparam logic [3:0][7:0] CTRL_MASK = {8'h03, 8'h3F, 8'h15, 8'h37};
	// alt_pin_ctrl_logic_event fields
	localparam int BIT_LOGIC_TABLE_ONE_ALT = 5;
	localparam int BIT_LOGIC_TABLE_ZERO_ALT = 4;
	localparam int BIT_EVENT_PIN_OUT_TWO_EN = 2;
	localparam int BIT_EVENT_PIN_OUT_ONE_EN = 1;
	localparam int BIT_EVENT_PIN_OUT_ZERO_EN = 0;
	// alt_pin_ctrl_comm fields
	localparam int BIT_TWO_WIRE_ALT = 4;
	localparam int BIT_SERIAL_PERIPH_ALT = 2;
	localparam int BIT_ASYNC_SERIAL_ALT = 0;
	// alt_pin_ctrl_waveform fields: bit n moves waveform output n
	localparam int BIT_WAVE_OUT_ZERO_ALT = 0;
	localparam int NUM_WAVE = 6;
	localparam int NUM_WAVE_LOW = 3;
	// alt_pin_ctrl_timer_b fields: bit n moves timer B instance n
	localparam int BIT_TIMER_B_ZERO_ALT = 0;
	localparam int NUM_TIMER_B = 2;
	// signal group widths
	localparam int NUM_LUT = 2;
	localparam int NUM_EVENT = 3;
	localparam int NUM_TWI = 2;
	localparam int NUM_SPI = 4;
	localparam int NUM_USART = 3;
	// one pad driver: level and output enable
	typedef struct packed {
		logic out;
		logic oe;
	} pad_s;
	localparam pad_s PAD_IDLE = '{out: 1'b0, oe: 1'b0};
endpackage : pin_location_selector_pkg
`default_nettype wire

// ### design/pin_steer.sv
// registered steering of a signal group between default and alternative pins
`default_nettype none
module pin_steer #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic sel_alt,
	input wire pin_location_selector_pkg::pad_s [W-1:0] periph_drv,
	input wire logic [W-1:0] dflt_in,
	input wire logic [W-1:0] alt_in,
	output logic [W-1:0] periph_in,
	output pin_location_selector_pkg::pad_s [W-1:0] dflt_pad,
	output pin_location_selector_pkg::pad_s [W-1:0] alt_pad
);
	pin_location_selector_pkg::pad_s [W-1:0] next_dflt_pad;
	pin_location_selector_pkg::pad_s [W-1:0] next_alt_pad;
	logic [W-1:0] next_periph_in;

	// the unselected pin is released so it can serve its port function
	always_comb
	begin
		for (int i = 0; i < W; i++)
		begin
			next_dflt_pad[i] = sel_alt ? pin_location_selector_pkg::PAD_IDLE
				: periph_drv[i];
			next_alt_pad[i] = sel_alt ? periph_drv[i]
				: pin_location_selector_pkg::PAD_IDLE;
		end
		next_periph_in = sel_alt ? alt_in : dflt_in;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dflt_pad <= '0;
			alt_pad <= '0;
			periph_in <= '0;
		end
		else
		begin
			dflt_pad <= next_dflt_pad;
			alt_pad <= next_alt_pad;
			periph_in <= next_periph_in;
		end
	end
endmodule : pin_steer
`default_nettype wire

// ### design/event_pin_gate.sv
// registered enable of event channel levels onto their pins
`default_nettype none
module event_pin_gate #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] enable,
	input wire logic [W-1:0] event_level,
	output pin_location_selector_pkg::pad_s [W-1:0] event_pad
);
	pin_location_selector_pkg::pad_s [W-1:0] next_event_pad;

	// a disabled output leaves the pin undriven, not driven low
	always_comb
	begin
		for (int i = 0; i < W; i++)
		begin
			next_event_pad[i].out = enable[i] & event_level[i];
			next_event_pad[i].oe = enable[i];
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			event_pad <= '0;
		end
		else
		begin
			event_pad <= next_event_pad;
		end
	end
endmodule : event_pin_gate
`default_nettype wire

// ### design/pin_location_selector.sv
// alternative pin location selector: control registers and pin steering
`default_nettype none

// Notes on behaviour
// - bit 5 of the first register moves lookup table 1 output to its alt pin.
// - bit 4 of the first register moves lookup table 0 output to its alt pin.
// - bits 2..0 of the first register each drive one event output onto a pin.
// - bit 4 of the second register moves the two-wire pins to alt pins.
// - bit 2 of the second register moves the SPI pins to alt pins.
// - bit 0 of the second register moves the USART pins to alt pins.
// - bits 5..3 of the third register move waveform outputs 5..3, split only.
// - bits 2..0 of the third register move waveform outputs 2..0 in any mode.
// - bit 1 of the fourth register moves timer B instance 1 to its alt pin.
// - bit 0 of the fourth register moves timer B instance 0 to its alt pin.
module pin_location_selector (
	input wire logic clk,
	input wire logic arst_n,
	// register port
	input wire logic [pin_location_selector_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pin_location_selector_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pin_location_selector_pkg::DATA_W-1:0] reg_rdata,
	// lookup table outputs
	input wire pin_location_selector_pkg::pad_s [1:0] lut_drv,
	output pin_location_selector_pkg::pad_s [1:0] lut_dflt_pad,
	output pin_location_selector_pkg::pad_s [1:0] lut_alt_pad,
	// event system outputs
	input wire logic [2:0] event_level,
	output pin_location_selector_pkg::pad_s [2:0] event_pad,
	// two-wire interface: clock, data
	input wire pin_location_selector_pkg::pad_s [1:0] twi_drv,
	output logic [1:0] twi_in,
	input wire logic [1:0] twi_dflt_in,
	input wire logic [1:0] twi_alt_in,
	output pin_location_selector_pkg::pad_s [1:0] twi_dflt_pad,
	output pin_location_selector_pkg::pad_s [1:0] twi_alt_pad,
	// SPI: clock, out, in, select
	input wire pin_location_selector_pkg::pad_s [3:0] spi_drv,
	output logic [3:0] spi_in,
	input wire logic [3:0] spi_dflt_in,
	input wire logic [3:0] spi_alt_in,
	output pin_location_selector_pkg::pad_s [3:0] spi_dflt_pad,
	output pin_location_selector_pkg::pad_s [3:0] spi_alt_pad,
	// USART: transmit, receive, clock
	input wire pin_location_selector_pkg::pad_s [2:0] usart_drv,
	output logic [2:0] usart_in,
	input wire logic [2:0] usart_dflt_in,
	input wire logic [2:0] usart_alt_in,
	output pin_location_selector_pkg::pad_s [2:0] usart_dflt_pad,
	output pin_location_selector_pkg::pad_s [2:0] usart_alt_pad,
	// timer A waveform outputs
	input wire logic wave_split_mode,
	input wire pin_location_selector_pkg::pad_s [5:0] wave_drv,
	output pin_location_selector_pkg::pad_s [5:0] wave_dflt_pad,
	output pin_location_selector_pkg::pad_s [5:0] wave_alt_pad,
	// timer B outputs
	input wire pin_location_selector_pkg::pad_s [1:0] timer_b_drv,
	output pin_location_selector_pkg::pad_s [1:0] timer_b_dflt_pad,
	output pin_location_selector_pkg::pad_s [1:0] timer_b_alt_pad
);
	logic [pin_location_selector_pkg::NUM_CTRL-1:0][7:0] ctrl;
	logic [pin_location_selector_pkg::NUM_CTRL-1:0][7:0] next_ctrl;
	logic [pin_location_selector_pkg::DATA_W-1:0] next_reg_rdata;
	logic [7:0] alt_pin_ctrl_logic_event;
	logic [7:0] alt_pin_ctrl_comm;
	logic [7:0] alt_pin_ctrl_waveform;
	logic [7:0] alt_pin_ctrl_timer_b;
	logic [5:0] wave_sel;
	logic [2:0] event_en;

	assign alt_pin_ctrl_logic_event =
		ctrl[pin_location_selector_pkg::OFS_CTRL_LOGIC_EVENT[1:0]];
	assign alt_pin_ctrl_comm =
		ctrl[pin_location_selector_pkg::OFS_CTRL_COMM[1:0]];
	assign alt_pin_ctrl_waveform =
		ctrl[pin_location_selector_pkg::OFS_CTRL_WAVEFORM[1:0]];
	assign alt_pin_ctrl_timer_b =
		ctrl[pin_location_selector_pkg::OFS_CTRL_TIMER_B[1:0]];

	// control registers; only offsets below the register count are mapped
	always_comb
	begin
		next_ctrl = ctrl;
		next_reg_rdata = pin_location_selector_pkg::RDATA_IDLE;
		for (int i = 0; i < pin_location_selector_pkg::NUM_CTRL; i++)
		begin
			if (reg_wr && reg_addr == 4'(i))
			begin
				next_ctrl[i] = reg_wdata
					& pin_location_selector_pkg::CTRL_MASK[i];
			end
			if (reg_rd && reg_addr == 4'(i))
			begin
				// read data only in the cycle after the strobe
				next_reg_rdata = ctrl[i]
					& pin_location_selector_pkg::CTRL_MASK[i];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl <= {pin_location_selector_pkg::NUM_CTRL{
				pin_location_selector_pkg::CTRL_RESET}};
			reg_rdata <= pin_location_selector_pkg::RDATA_IDLE;
		end
		else
		begin
			ctrl <= next_ctrl;
			reg_rdata <= next_reg_rdata;
		end
	end

	// upper waveform selections are held off outside split mode
	always_comb
	begin
		for (int i = 0; i < pin_location_selector_pkg::NUM_WAVE; i++)
		begin
			if (i < pin_location_selector_pkg::NUM_WAVE_LOW)
			begin
				wave_sel[i] = alt_pin_ctrl_waveform[
					pin_location_selector_pkg::BIT_WAVE_OUT_ZERO_ALT + i];
			end
			else
			begin
				wave_sel[i] = wave_split_mode & alt_pin_ctrl_waveform[
					pin_location_selector_pkg::BIT_WAVE_OUT_ZERO_ALT + i];
			end
		end
	end

	assign event_en = {
		alt_pin_ctrl_logic_event[
			pin_location_selector_pkg::BIT_EVENT_PIN_OUT_TWO_EN],
		alt_pin_ctrl_logic_event[
			pin_location_selector_pkg::BIT_EVENT_PIN_OUT_ONE_EN],
		alt_pin_ctrl_logic_event[
			pin_location_selector_pkg::BIT_EVENT_PIN_OUT_ZERO_EN]};

	// event outputs only drive while enabled
	event_pin_gate #(
		.W(pin_location_selector_pkg::NUM_EVENT)
	) u_event_gate (
		.clk(clk),
		.arst_n(arst_n),
		.enable(event_en),
		.event_level(event_level),
		.event_pad(event_pad)
	);

	// lookup table zero
	pin_steer #(
		.W(1)
	) u_lut_zero (
		.clk(clk),
		.arst_n(arst_n),
		.sel_alt(alt_pin_ctrl_logic_event[
			pin_location_selector_pkg::BIT_LOGIC_TABLE_ZERO_ALT]),
		.periph_drv(lut_drv[0]),
		.dflt_in(1'b0),
		.alt_in(1'b0),
		.periph_in(),
		.dflt_pad(lut_dflt_pad[0]),
		.alt_pad(lut_alt_pad[0])
	);

	// lookup table one
	pin_steer #(
		.W(1)
	) u_lut_one (
		.clk(clk),
		.arst_n(arst_n),
		.sel_alt(alt_pin_ctrl_logic_event[
			pin_location_selector_pkg::BIT_LOGIC_TABLE_ONE_ALT]),
		.periph_drv(lut_drv[1]),
		.dflt_in(1'b0),
		.alt_in(1'b0),
		.periph_in(),
		.dflt_pad(lut_dflt_pad[1]),
		.alt_pad(lut_alt_pad[1])
	);

	// whole serial groups move together so a bus never straddles locations
	pin_steer #(
		.W(pin_location_selector_pkg::NUM_TWI)
	) u_twi (
		.clk(clk),
		.arst_n(arst_n),
		.sel_alt(alt_pin_ctrl_comm[
			pin_location_selector_pkg::BIT_TWO_WIRE_ALT]),
		.periph_drv(twi_drv),
		.dflt_in(twi_dflt_in),
		.alt_in(twi_alt_in),
		.periph_in(twi_in),
		.dflt_pad(twi_dflt_pad),
		.alt_pad(twi_alt_pad)
	);

	pin_steer #(
		.W(pin_location_selector_pkg::NUM_SPI)
	) u_spi (
		.clk(clk),
		.arst_n(arst_n),
		.sel_alt(alt_pin_ctrl_comm[
			pin_location_selector_pkg::BIT_SERIAL_PERIPH_ALT]),
		.periph_drv(spi_drv),
		.dflt_in(spi_dflt_in),
		.alt_in(spi_alt_in),
		.periph_in(spi_in),
		.dflt_pad(spi_dflt_pad),
		.alt_pad(spi_alt_pad)
	);

	pin_steer #(
		.W(pin_location_selector_pkg::NUM_USART)
	) u_usart (
		.clk(clk),
		.arst_n(arst_n),
		.sel_alt(alt_pin_ctrl_comm[
			pin_location_selector_pkg::BIT_ASYNC_SERIAL_ALT]),
		.periph_drv(usart_drv),
		.dflt_in(usart_dflt_in),
		.alt_in(usart_alt_in),
		.periph_in(usart_in),
		.dflt_pad(usart_dflt_pad),
		.alt_pad(usart_alt_pad)
	);

	// each waveform output steers on its own
	for (genvar g = 0; g < pin_location_selector_pkg::NUM_WAVE; g++)
	begin : g_wave
		pin_steer #(
			.W(1)
		) u_wave (
			.clk(clk),
			.arst_n(arst_n),
			.sel_alt(wave_sel[g]),
			.periph_drv(wave_drv[g]),
			.dflt_in(1'b0),
			.alt_in(1'b0),
			.periph_in(),
			.dflt_pad(wave_dflt_pad[g]),
			.alt_pad(wave_alt_pad[g])
		);
	end

	// each timer B output steers on its own
	for (genvar g = 0; g < pin_location_selector_pkg::NUM_TIMER_B; g++)
	begin : g_timer_b
		pin_steer #(
			.W(1)
		) u_timer_b (
			.clk(clk),
			.arst_n(arst_n),
			.sel_alt(alt_pin_ctrl_timer_b[
				pin_location_selector_pkg::BIT_TIMER_B_ZERO_ALT + g]),
			.periph_drv(timer_b_drv[g]),
			.dflt_in(1'b0),
			.alt_in(1'b0),
			.periph_in(),
			.dflt_pad(timer_b_dflt_pad[g]),
			.alt_pad(timer_b_alt_pad[g])
		);
	end
endmodule : pin_location_selector
`default_nettype wire

// ### verif/pin_location_selector_sva.sv
// port assertions for the pin location selector
`default_nettype none
module pin_location_selector_sva (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire pin_location_selector_pkg::pad_s [1:0] lut_drv,
	input wire pin_location_selector_pkg::pad_s [1:0] lut_dflt_pad,
	input wire pin_location_selector_pkg::pad_s [1:0] lut_alt_pad,
	input wire logic [2:0] event_level,
	input wire pin_location_selector_pkg::pad_s [2:0] event_pad,
	input wire pin_location_selector_pkg::pad_s [1:0] twi_drv,
	input wire pin_location_selector_pkg::pad_s [1:0] twi_dflt_pad,
	input wire logic [1:0] twi_in,
	input wire logic [1:0] twi_dflt_in,
	input wire pin_location_selector_pkg::pad_s [2:0] usart_alt_pad,
	input wire logic [2:0] usart_in,
	input wire logic [2:0] usart_alt_in,
	input wire logic wave_split_mode,
	input wire pin_location_selector_pkg::pad_s [5:0] wave_alt_pad
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not idle");
	unmap_rd_a: assert property (reg_rd && reg_addr > 4'h3 |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	mask_rd_a: assert property (reg_rd && reg_addr == 4'h0 |=>
		(reg_rdata & 8'hC8) == 8'h00) else $error("unused bits read set");
	// one pin only carries the table output, never both
	lut_route_a: assert property ($past(arst_n) |->
		(lut_dflt_pad[1] | lut_alt_pad[1]) == $past(lut_drv[1]) &&
		(lut_dflt_pad[1] & lut_alt_pad[1]) == 2'h0)
		else $error("table output misrouted");
	event_gate_a: assert property (event_pad[2].out ==
		(event_pad[2].oe & $past(event_level[2])))
		else $error("event pin level wrong");
	wave_norm_a: assert property (!$past(wave_split_mode) |->
		wave_alt_pad[5:3] == 6'h00) else $error("upper wave moved");
	twi_group_a: assert property (twi_dflt_pad[0].oe &&
		$past(twi_drv[1].oe) |-> twi_dflt_pad[1].oe &&
		twi_in == $past(twi_dflt_in)) else $error("two-wire split");
	usart_alt_a: assert property (usart_alt_pad[2].oe |->
		usart_in == $past(usart_alt_in)) else $error("usart input wrong");
endmodule : pin_location_selector_sva
bind pin_location_selector pin_location_selector_sva chk (.*);
`default_nettype wire

// ### verif/pin_far_side.sv
// far-side model: levels seen at the default and alternative pins
`default_nettype none
module pin_far_side (
	input wire logic flip,
	output logic [1:0] twi_dflt_in,
	output logic [1:0] twi_alt_in,
	output logic [3:0] spi_dflt_in,
	output logic [3:0] spi_alt_in,
	output logic [2:0] usart_dflt_in,
	output logic [2:0] usart_alt_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// alt levels are the inverse of default so a wrong select shows
	assign twi_dflt_in = {2{flip}} ^ 2'h1;
	assign twi_alt_in = ~twi_dflt_in;
	assign spi_dflt_in = {4{flip}} ^ 4'h5;
	assign spi_alt_in = ~spi_dflt_in;
	assign usart_dflt_in = {3{flip}} ^ 3'h5;
	assign usart_alt_in = ~usart_dflt_in;
endmodule : pin_far_side
`default_nettype wire

// ### verif/pin_location_selector_bench.sv
// register-driven bench for the pin location selector
`default_nettype none
module pin_location_selector_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, arst_n, reg_wr, reg_rd, wave_split_mode, flip;
	logic [3:0] reg_addr, spi_in, spi_dflt_in, spi_alt_in;
	logic [7:0] reg_wdata, reg_rdata;
	logic [2:0] event_level, usart_in, usart_dflt_in, usart_alt_in;
	logic [1:0] twi_in, twi_dflt_in, twi_alt_in;
	pin_location_selector_pkg::pad_s [1:0] lut_drv, lut_dflt_pad;
	pin_location_selector_pkg::pad_s [1:0] lut_alt_pad, twi_drv;
	pin_location_selector_pkg::pad_s [1:0] twi_dflt_pad, twi_alt_pad;
	pin_location_selector_pkg::pad_s [1:0] timer_b_drv, timer_b_dflt_pad;
	pin_location_selector_pkg::pad_s [1:0] timer_b_alt_pad;
	pin_location_selector_pkg::pad_s [3:0] spi_drv, spi_dflt_pad;
	pin_location_selector_pkg::pad_s [3:0] spi_alt_pad;
	pin_location_selector_pkg::pad_s [2:0] event_pad, usart_drv;
	pin_location_selector_pkg::pad_s [2:0] usart_dflt_pad, usart_alt_pad;
	pin_location_selector_pkg::pad_s [5:0] wave_drv, wave_dflt_pad;
	pin_location_selector_pkg::pad_s [5:0] wave_alt_pad;
	logic [3:0][7:0] mask = {8'h03, 8'h3F, 8'h15, 8'h37};
	int miscompares = 0;
	int tests_run = 0;

	pin_location_selector uut (.*);
	pin_far_side far (.*);

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// every drive input follows one pattern so no input stays tied
	task automatic setd(input logic [11:0] v);
		lut_drv <= v[3:0];
		twi_drv <= v[3:0];
		timer_b_drv <= v[3:0];
		spi_drv <= v[7:0];
		usart_drv <= v[5:0];
		wave_drv <= v;
		event_level <= v[2:0];
	endtask : setd

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, exp);
	endtask : rd

	// steering flops load one edge after the control register
	task automatic settle();
		@(posedge clk);
		@(negedge clk);
	endtask : settle

	initial
	begin
		repeat (5000) @(posedge clk);
		miscompares++;
		results();
	end

	initial
	begin
		arst_n = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		wave_split_mode = 1'b0;
		flip = 1'b0;
		setd(12'hFFF);
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		for (int a = 0; a < 4; a++)
			rd(a[3:0], 8'h00);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		$display("reset and unmapped test done");
		for (int a = 0; a < 4; a++)
			wr(a[3:0], 8'hFF);
		for (int a = 0; a < 4; a++)
			rd(a[3:0], mask[a]);
		settle();
		chk(lut_alt_pad, 16'h000F);
		chk(lut_dflt_pad, 16'h0000);
		chk(event_pad, 16'h003F);
		chk(twi_alt_pad, 16'h000F);
		chk(twi_in, 16'h0002);
		chk(spi_alt_pad, 16'h00FF);
		chk(spi_in, 16'h000A);
		chk(usart_alt_pad, 16'h003F);
		chk(usart_in, 16'h0002);
		chk(wave_alt_pad, 16'h003F);
		chk(wave_dflt_pad, 16'h0FC0);
		chk(timer_b_alt_pad, 16'h000F);
		@(posedge clk);
		wave_split_mode <= 1'b1;
		settle();
		chk(wave_alt_pad, 16'h0FFF);
		chk(wave_dflt_pad, 16'h0000);
		$display("alternative routing test done");
		@(posedge clk);
		flip <= 1'b1;
		setd(12'h5A6);
		for (int a = 0; a < 4; a++)
			wr(a[3:0], 8'h00);
		settle();
		chk(lut_dflt_pad, 16'h0006);
		chk(lut_alt_pad, 16'h0000);
		chk(event_pad, 16'h0000);
		chk(twi_dflt_pad, 16'h0006);
		chk(twi_in, 16'h0002);
		chk(spi_dflt_pad, 16'h00A6);
		chk(spi_in, 16'h000A);
		chk(usart_dflt_pad, 16'h0026);
		chk(usart_in, 16'h0002);
		chk(wave_dflt_pad, 16'h05A6);
		chk(timer_b_dflt_pad, 16'h0006);
		$display("default routing test done");
		// one bit per group, alternate bits for waveform, so a swapped field position shows
		wr(4'h0, 8'h22);
		wr(4'h1, 8'h04);
		wr(4'h2, 8'h2A);
		wr(4'h3, 8'h02);
		settle();
		chk(lut_alt_pad, 16'h0004);
		chk(lut_dflt_pad, 16'h0002);
		chk(event_pad, 16'h000C);
		chk(spi_alt_pad, 16'h00A6);
		chk(spi_in, 16'h0005);
		chk(twi_dflt_pad, 16'h0006);
		chk(twi_in, 16'h0002);
		chk(usart_dflt_pad, 16'h0026);
		chk(usart_in, 16'h0002);
		chk(wave_alt_pad, 16'h0484);
		chk(wave_dflt_pad, 16'h0122);
		chk(timer_b_alt_pad, 16'h0004);
		chk(timer_b_dflt_pad, 16'h0002);
		$display("single selection test done");
		// reset in mid-run must clear what software wrote
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		for (int a = 0; a < 4; a++)
			rd(a[3:0], 8'h00);
		chk(lut_alt_pad, 16'h0000);
		chk(wave_alt_pad, 16'h0000);
		chk(timer_b_alt_pad, 16'h0000);
		$display("mid-run reset test done");
		results();
	end
endmodule : pin_location_selector_bench
`default_nettype wire
